/* verilog/hsu_cfg.svh */
// Constants for the host serial port: timing, character codes and buffer sizes.
`ifndef HSU_CFG_SVH
`define HSU_CFG_SVH

`define HSU_CLK_HZ       100000000
`define HSU_BPS_DEFAULT  115200
`define HSU_BPS_MIN      9600
`define HSU_BPS_MAX      4000000
`define HSU_DIV_DEFAULT  ((`HSU_CLK_HZ + `HSU_BPS_DEFAULT / 2) / `HSU_BPS_DEFAULT)
`define HSU_DIV_MIN      ((`HSU_CLK_HZ + `HSU_BPS_MAX - 1) / `HSU_BPS_MAX)
`define HSU_DIV_MAX      (`HSU_CLK_HZ / `HSU_BPS_MIN)

`define HSU_FIFO_DEPTH   11'h410
`define HSU_FIFO_LAST    11'h40f
`define HSU_RTS_MARGIN   11'h010

`define HSU_CHAR_XON     8'h11
`define HSU_CHAR_XOFF    8'h13
`define HSU_SLIP_END     8'hc0
`define HSU_SLIP_ESC     8'hdb
`define HSU_SLIP_ESC_END 8'hdc
`define HSU_SLIP_ESC_ESC 8'hdd

`endif

/* verilog/hsu_pkg.sv */
// Types shared by the host serial port modules.
package hsu_pkg;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } hsu_byte_t;

  typedef enum logic [3:0] {
    HSU_LN_IDLE  = 4'h1,
    HSU_LN_START = 4'h2,
    HSU_LN_DATA  = 4'h4,
    HSU_LN_STOP  = 4'h8
  } hsu_line_t;

  typedef enum logic [4:0] {
    HSU_EN_IDLE = 5'h01,
    HSU_EN_SOF  = 5'h02,
    HSU_EN_BYTE = 5'h04,
    HSU_EN_ESC  = 5'h08,
    HSU_EN_EOF  = 5'h10
  } hsu_enc_t;

  typedef enum logic [2:0] {
    HSU_AB_OFF  = 3'h1,
    HSU_AB_WAIT = 3'h2,
    HSU_AB_MEAS = 3'h4
  } hsu_ab_t;

endpackage : hsu_pkg

/* verilog/hsu_rx.sv */
// Character receiver: samples each bit at its midpoint.
`timescale 1ns/1ns
`include "hsu_cfg.svh"
module hsu_rx (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [15:0] divisor,
  input  wire logic        serial_in,
  output logic             byte_valid,
  output logic [7:0]       byte_data,
  output logic             frame_error
);
  import hsu_pkg::*;

  hsu_line_t   state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [2:0]  bitn, next_bitn;
  logic [7:0]  shreg, next_shreg;
  logic        next_byte_valid, next_frame_error;

  // Midpoint sampling leaves half a bit of slack for the combined rate error.
  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_bitn        = bitn;
    next_shreg       = shreg;
    next_byte_valid  = 1'b0;
    next_frame_error = 1'b0;
    case (state)
      HSU_LN_IDLE: begin
        if (!serial_in) begin
          next_state = HSU_LN_START;
          next_cnt   = divisor >> 1;
        end
      end
      HSU_LN_START: begin
        if (cnt == 16'h0000) begin
          next_cnt  = divisor - 16'h0001;
          next_bitn = 3'h0;
          next_state = serial_in ? HSU_LN_IDLE : HSU_LN_DATA;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      HSU_LN_DATA: begin
        if (cnt == 16'h0000) begin
          next_shreg = {serial_in, shreg[7:1]};
          next_cnt   = divisor - 16'h0001;
          next_bitn  = bitn + 3'h1;
          if (bitn == 3'h7) begin
            next_state = HSU_LN_STOP;
          end
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      HSU_LN_STOP: begin
        if (cnt == 16'h0000) begin
          next_byte_valid  = serial_in;
          next_frame_error = !serial_in;
          next_state       = HSU_LN_IDLE;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: begin
        next_state = HSU_LN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state       <= HSU_LN_IDLE;
      cnt         <= 16'h0000;
      bitn        <= 3'h0;
      shreg       <= 8'h00;
      byte_valid  <= 1'b0;
      frame_error <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      bitn        <= next_bitn;
      shreg       <= next_shreg;
      byte_valid  <= next_byte_valid;
      frame_error <= next_frame_error;
    end
  end

  assign byte_data = shreg;

endmodule : hsu_rx

/* verilog/hsu_tx.sv */
// Character transmitter: start bit, eight data bits LSB first, one stop bit.
`timescale 1ns/1ns
`include "hsu_cfg.svh"
module hsu_tx (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [15:0] divisor,
  input  wire logic        start,
  input  wire logic [7:0]  data,
  output logic             ready,
  output logic             serial_out
);
  import hsu_pkg::*;

  hsu_line_t   state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [2:0]  bitn, next_bitn;
  logic [7:0]  shreg, next_shreg;
  logic        next_serial_out;

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_bitn       = bitn;
    next_shreg      = shreg;
    next_serial_out = serial_out;
    case (state)
      HSU_LN_IDLE: begin
        next_serial_out = 1'b1;
        if (start) begin
          next_state      = HSU_LN_START;
          next_shreg      = data;
          next_cnt        = divisor - 16'h0001;
          next_serial_out = 1'b0;
        end
      end
      HSU_LN_START: begin
        if (cnt == 16'h0000) begin
          next_state      = HSU_LN_DATA;
          next_bitn       = 3'h0;
          next_cnt        = divisor - 16'h0001;
          next_serial_out = shreg[0];
          next_shreg      = {1'b0, shreg[7:1]};
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      HSU_LN_DATA: begin
        if (cnt == 16'h0000) begin
          next_cnt  = divisor - 16'h0001;
          next_bitn = bitn + 3'h1;
          if (bitn == 3'h7) begin
            next_state      = HSU_LN_STOP;
            next_serial_out = 1'b1;
          end else begin
            next_serial_out = shreg[0];
            next_shreg      = {1'b0, shreg[7:1]};
          end
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      HSU_LN_STOP: begin
        if (cnt == 16'h0000) begin
          next_state = HSU_LN_IDLE;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: begin
        next_state = HSU_LN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state      <= HSU_LN_IDLE;
      cnt        <= 16'h0000;
      bitn       <= 3'h0;
      shreg      <= 8'h00;
      serial_out <= 1'b1;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      bitn       <= next_bitn;
      shreg      <= next_shreg;
      serial_out <= next_serial_out;
    end
  end

  assign ready = (state == HSU_LN_IDLE);

endmodule : hsu_tx

/* verilog/hsu_top.sv */
// Host serial port: rate control, autobaud, flow control, SLIP framing and FIFOs.
`timescale 1ns/1ns
`include "hsu_cfg.svh"
module hsu_top (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             hci_serial_in,
  output logic                  hci_serial_out,
  output logic                  hci_request_to_send_n,
  input  wire logic             hci_clear_to_send_n,
  input  wire logic             h5_mode,
  input  wire logic             xon_xoff_en,
  input  wire logic [15:0]      cfg_divisor,
  input  wire logic             cfg_load,
  input  wire logic             autobaud_start,
  output logic                  autobaud_busy,
  output logic [15:0]           rate_divisor,
  input  wire logic             sleep_mode,
  output logic                  wake_event,
  input  wire hsu_pkg::hsu_byte_t tx_in,
  input  wire logic             tx_in_valid,
  output logic                  tx_in_ready,
  output hsu_pkg::hsu_byte_t    rx_out,
  output logic                  rx_out_valid,
  input  wire logic             rx_out_ready,
  output logic                  rx_overrun,
  output logic                  rx_frame_error,
  output logic                  tx_paused
);
  import hsu_pkg::*;

  function automatic logic [15:0] clamp_div(input logic [15:0] v);
    if (v < 16'(`HSU_DIV_MIN)) begin
      return 16'(`HSU_DIV_MIN);
    end else if (v > 16'(`HSU_DIV_MAX)) begin
      return 16'(`HSU_DIV_MAX);
    end
    return v;
  endfunction : clamp_div

  function automatic logic [10:0] ptr_inc(input logic [10:0] p);
    return (p == `HSU_FIFO_LAST) ? 11'h000 : p + 11'h001;
  endfunction : ptr_inc

  // Rate divisor and autobaud.
  hsu_ab_t     ab_state, next_ab_state;
  logic [15:0] ab_cnt, next_ab_cnt;
  logic [15:0] next_rate_divisor;
  logic        next_autobaud_busy;

  // Autobaud expects a first character whose bit 0 is one, so the low pulse is one bit.
  always_comb begin
    next_ab_state     = ab_state;
    next_ab_cnt       = ab_cnt;
    next_rate_divisor = rate_divisor;
    case (ab_state)
      HSU_AB_OFF: begin
        if (autobaud_start) begin
          next_ab_state = HSU_AB_WAIT;
        end
      end
      HSU_AB_WAIT: begin
        if (!hci_serial_in) begin
          next_ab_state = HSU_AB_MEAS;
          next_ab_cnt   = 16'h0001;
        end
      end
      HSU_AB_MEAS: begin
        if (hci_serial_in) begin
          next_ab_state     = HSU_AB_OFF;
          next_rate_divisor = clamp_div(ab_cnt);
        end else if (ab_cnt != 16'hffff) begin
          next_ab_cnt = ab_cnt + 16'h0001;
        end
      end
      default: begin
        next_ab_state = HSU_AB_OFF;
      end
    endcase
    if (cfg_load) begin
      next_rate_divisor = clamp_div(cfg_divisor);
      next_ab_state     = HSU_AB_OFF;
    end
    next_autobaud_busy = (next_ab_state != HSU_AB_OFF);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ab_state      <= HSU_AB_OFF;
      ab_cnt        <= 16'h0000;
      rate_divisor  <= 16'(`HSU_DIV_DEFAULT);
      autobaud_busy <= 1'b0;
    end else begin
      ab_state      <= next_ab_state;
      ab_cnt        <= next_ab_cnt;
      rate_divisor  <= next_rate_divisor;
      autobaud_busy <= next_autobaud_busy;
    end
  end

  // Receive path.
  logic       rx_byte_valid;
  logic [7:0] rx_byte;
  logic       rx_ferr;

  hsu_rx u_rx (
    .clk         (clk),
    .srst        (srst),
    .divisor     (rate_divisor),
    .serial_in   (hci_serial_in),
    .byte_valid  (rx_byte_valid),
    .byte_data   (rx_byte),
    .frame_error (rx_ferr)
  );

  hsu_byte_t   rx_mem [0:1039];
  logic [10:0] rx_wr, next_rx_wr, rx_rd, next_rx_rd, rx_cnt, next_rx_cnt;
  logic        rx_esc, next_rx_esc;
  logic        rx_push, rx_pop, next_tx_paused, next_rx_overrun;
  hsu_byte_t   rx_push_val;
  hsu_byte_t   next_rx_out;
  logic        next_rx_out_valid, next_rts_n;

  always_comb begin
    rx_push        = 1'b0;
    rx_push_val    = '{last: 1'b0, data: rx_byte};
    next_rx_esc    = rx_esc;
    next_tx_paused = tx_paused;
    if (rx_byte_valid && !autobaud_busy) begin
      if (xon_xoff_en && rx_byte == `HSU_CHAR_XON) begin
        next_tx_paused = 1'b0;
      end else if (xon_xoff_en && rx_byte == `HSU_CHAR_XOFF) begin
        next_tx_paused = 1'b1;
      end else if (h5_mode && rx_esc) begin
        next_rx_esc = 1'b0;
        rx_push     = 1'b1;
        if (rx_byte == `HSU_SLIP_ESC_END) begin
          rx_push_val.data = `HSU_SLIP_END;
        end else if (rx_byte == `HSU_SLIP_ESC_ESC) begin
          rx_push_val.data = `HSU_SLIP_ESC;
        end
      end else if (h5_mode && rx_byte == `HSU_SLIP_END) begin
        rx_push     = 1'b1;
        rx_push_val = '{last: 1'b1, data: 8'h00};
      end else if (h5_mode && rx_byte == `HSU_SLIP_ESC) begin
        next_rx_esc = 1'b1;
      end else begin
        rx_push = 1'b1;
      end
    end
    if (!xon_xoff_en) begin
      next_tx_paused = 1'b0;
    end
    if (!h5_mode) begin
      next_rx_esc = 1'b0;
    end
    // A full FIFO drops the character and flags it rather than overwriting.
    next_rx_overrun = rx_push && (rx_cnt == `HSU_FIFO_DEPTH);
    rx_push         = rx_push && (rx_cnt != `HSU_FIFO_DEPTH);
    rx_pop          = (rx_cnt != 11'h000) && (!rx_out_valid || rx_out_ready);
    next_rx_out       = rx_out;
    next_rx_out_valid = rx_out_valid && !rx_out_ready;
    if (rx_pop) begin
      next_rx_out       = rx_mem[rx_rd];
      next_rx_out_valid = 1'b1;
    end
    next_rx_wr  = rx_push ? ptr_inc(rx_wr) : rx_wr;
    next_rx_rd  = rx_pop ? ptr_inc(rx_rd) : rx_rd;
    next_rx_cnt = rx_cnt + (rx_push ? 11'h001 : 11'h000) - (rx_pop ? 11'h001 : 11'h000);
    // Taken from the fill level after this cycle's push and pop, so the stop comes on the same edge as the push.
    next_rts_n  = (next_rx_cnt >= (`HSU_FIFO_DEPTH - `HSU_RTS_MARGIN));
  end

  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_mem[rx_wr] <= rx_push_val;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_wr                 <= 11'h000;
      rx_rd                 <= 11'h000;
      rx_cnt                <= 11'h000;
      rx_esc                <= 1'b0;
      tx_paused             <= 1'b0;
      rx_out                <= '0;
      rx_out_valid          <= 1'b0;
      rx_overrun            <= 1'b0;
      rx_frame_error        <= 1'b0;
      hci_request_to_send_n <= 1'b1;
    end else begin
      rx_wr                 <= next_rx_wr;
      rx_rd                 <= next_rx_rd;
      rx_cnt                <= next_rx_cnt;
      rx_esc                <= next_rx_esc;
      tx_paused             <= next_tx_paused;
      rx_out                <= next_rx_out;
      rx_out_valid          <= next_rx_out_valid;
      rx_overrun            <= next_rx_overrun;
      rx_frame_error        <= rx_ferr && !autobaud_busy;
      hci_request_to_send_n <= next_rts_n;
    end
  end

  // Transmit path.
  hsu_byte_t   tx_mem [0:1039];
  logic [10:0] tx_wr, next_tx_wr, tx_rd, next_tx_rd, tx_cnt, next_tx_cnt;
  logic        tx_push, tx_pop, next_tx_in_ready;
  hsu_enc_t    enc_state, next_enc_state;
  hsu_byte_t   cur, next_cur;
  logic        in_pkt, next_in_pkt;
  logic        line_ready, line_start, need_esc;
  logic [7:0]  line_data;

  always_comb begin
    need_esc = h5_mode && (cur.data == `HSU_SLIP_END || cur.data == `HSU_SLIP_ESC);
    case (enc_state)
      HSU_EN_SOF:  line_data = `HSU_SLIP_END;
      HSU_EN_EOF:  line_data = `HSU_SLIP_END;
      HSU_EN_BYTE: line_data = need_esc ? `HSU_SLIP_ESC : cur.data;
      HSU_EN_ESC:  line_data = (cur.data == `HSU_SLIP_END) ? `HSU_SLIP_ESC_END
                                                           : `HSU_SLIP_ESC_ESC;
      default:     line_data = cur.data;
    endcase
    // Each character waits for clear-to-send and no XOFF; the start bit follows next cycle.
    line_start = (enc_state != HSU_EN_IDLE) && line_ready && !hci_clear_to_send_n
                 && !tx_paused;
    tx_push        = tx_in_valid && tx_in_ready;
    tx_pop         = 1'b0;
    next_enc_state = enc_state;
    next_cur       = cur;
    next_in_pkt    = in_pkt;
    case (enc_state)
      HSU_EN_IDLE: begin
        if (tx_cnt != 11'h000) begin
          tx_pop   = 1'b1;
          next_cur = tx_mem[tx_rd];
          if (h5_mode && !in_pkt) begin
            next_enc_state = HSU_EN_SOF;
            next_in_pkt    = 1'b1;
          end else begin
            next_enc_state = HSU_EN_BYTE;
          end
        end
      end
      HSU_EN_SOF: begin
        if (line_start) begin
          next_enc_state = HSU_EN_BYTE;
        end
      end
      HSU_EN_BYTE, HSU_EN_ESC: begin
        if (line_start) begin
          if (enc_state == HSU_EN_BYTE && need_esc) begin
            next_enc_state = HSU_EN_ESC;
          end else if (h5_mode && cur.last) begin
            next_enc_state = HSU_EN_EOF;
          end else begin
            next_enc_state = HSU_EN_IDLE;
          end
        end
      end
      HSU_EN_EOF: begin
        if (line_start) begin
          next_enc_state = HSU_EN_IDLE;
          next_in_pkt    = 1'b0;
        end
      end
      default: begin
        next_enc_state = HSU_EN_IDLE;
      end
    endcase
    if (!h5_mode) begin
      next_in_pkt = 1'b0;
    end
    next_tx_wr       = tx_push ? ptr_inc(tx_wr) : tx_wr;
    next_tx_rd       = tx_pop ? ptr_inc(tx_rd) : tx_rd;
    next_tx_cnt      = tx_cnt + (tx_push ? 11'h001 : 11'h000) - (tx_pop ? 11'h001 : 11'h000);
    next_tx_in_ready = (next_tx_cnt != `HSU_FIFO_DEPTH);
  end

  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wr] <= tx_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_wr       <= 11'h000;
      tx_rd       <= 11'h000;
      tx_cnt      <= 11'h000;
      tx_in_ready <= 1'b0;
      enc_state   <= HSU_EN_IDLE;
      cur         <= '0;
      in_pkt      <= 1'b0;
    end else begin
      tx_wr       <= next_tx_wr;
      tx_rd       <= next_tx_rd;
      tx_cnt      <= next_tx_cnt;
      tx_in_ready <= next_tx_in_ready;
      enc_state   <= next_enc_state;
      cur         <= next_cur;
      in_pkt      <= next_in_pkt;
    end
  end

  hsu_tx u_tx (
    .clk        (clk),
    .srst       (srst),
    .divisor    (rate_divisor),
    .start      (line_start),
    .data       (line_data),
    .ready      (line_ready),
    .serial_out (hci_serial_out)
  );

  // Wake detection: any edge on either input while asleep.
  logic prev_rx, prev_cts, next_wake;

  always_comb begin
    next_wake = sleep_mode && ((prev_rx != hci_serial_in) ||
                               (prev_cts != hci_clear_to_send_n));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_rx    <= 1'b1;
      prev_cts   <= 1'b1;
      wake_event <= 1'b0;
    end else begin
      prev_rx    <= hci_serial_in;
      prev_cts   <= hci_clear_to_send_n;
      wake_event <= next_wake;
    end
  end

endmodule : hsu_top

/* dv/hsu_top_properties.sv */
// Port checker for the host serial port.
`timescale 1ns/1ns
module hsu_props
  import hsu_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       hci_serial_in,
  input wire logic       hci_serial_out,
  input wire logic       hci_request_to_send_n,
  input wire logic       hci_clear_to_send_n,
  input wire logic       xon_xoff_en,
  input wire logic [15:0] cfg_divisor,
  input wire logic       cfg_load,
  input wire logic       autobaud_start,
  input wire logic       autobaud_busy,
  input wire logic [15:0] rate_divisor,
  input wire logic       sleep_mode,
  input wire logic       wake_event,
  input wire logic       tx_in_ready,
  input wire hsu_byte_t  rx_out,
  input wire logic       rx_out_valid,
  input wire logic       rx_out_ready,
  input wire logic       tx_paused
);
  logic [15:0] cl;
  assign cl = (cfg_divisor < 16'h0019) ? 16'h0019 :
              (cfg_divisor > 16'h28b0) ? 16'h28b0 : cfg_divisor;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_idle: assert property (disable iff (1'b0) srst |=> hci_request_to_send_n &&
    hci_serial_out && !tx_in_ready && rate_divisor == 16'h0364) else $error("reset values");
  a_rts_release: assert property ($fell(srst) |-> hci_request_to_send_n
    ##1 !hci_request_to_send_n) else $error("rts after reset");
  a_rate_load: assert property (cfg_load |=> rate_divisor == $past(cl))
    else $error("rate load");
  a_load_cancel: assert property (cfg_load |=> !autobaud_busy)
    else $error("load cancel");
  a_arm_busy: assert property (autobaud_start && !cfg_load |=> autobaud_busy)
    else $error("autobaud arm");
  a_wake_edge: assert property (sleep_mode && ($changed(hci_serial_in) ||
    $changed(hci_clear_to_send_n)) |=> wake_event) else $error("wake missing");
  a_wake_quiet: assert property (!sleep_mode && !$past(sleep_mode) |=> !wake_event)
    else $error("wake awake");
  a_pause_off: assert property (!xon_xoff_en |=> !tx_paused)
    else $error("pause stuck");
  a_rx_hold: assert property (rx_out_valid && !rx_out_ready |=> rx_out_valid &&
    $stable(rx_out)) else $error("rx output moved");
  c_read: cover property (rx_out_valid && rx_out_ready);
  c_wake: cover property (wake_event);
  c_pause: cover property (tx_paused);
endmodule : hsu_props

bind hsu_top hsu_props chk_u (.clk, .srst, .hci_serial_in, .hci_serial_out,
  .hci_request_to_send_n, .hci_clear_to_send_n, .xon_xoff_en, .cfg_divisor, .cfg_load,
  .autobaud_start, .autobaud_busy, .rate_divisor, .sleep_mode, .wake_event, .tx_in_ready,
  .rx_out, .rx_out_valid, .rx_out_ready, .tx_paused);

/* dv/hsu_host_model.sv */
// Host end of the serial link: frames bytes out and collects bytes back.
`timescale 1ns/1ns
module hsu_host_model (
  input  wire logic clk,
  input  wire logic dev_out,
  input  wire logic rts_n,
  output logic      host_out,
  output logic      cts_n
);
  int         div = 868;
  logic       stop_bit = 1'b1;
  logic [7:0] got[$];
  logic [7:0] rb;
  initial begin
    host_out = 1'b1;
    cts_n = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {stop_bit, b, 1'b0};
    while (rts_n) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) #1;
      host_out = f[i];
      repeat (div - 1) @(posedge clk);
    end
    // A low stop bit would otherwise leave the line low after a framing test.
    #1;
    host_out = 1'b1;
  endtask : send
  // Only called between characters, so the stop-bit setup margin always holds.
  task automatic set_cts(input logic v);
    @(posedge clk) #1;
    cts_n = v;
  endtask : set_cts
  always begin
    @(negedge dev_out);
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk);
      rb[i] = dev_out;
    end
    repeat (div) @(posedge clk);
    if (dev_out) got.push_back(rb);
  end
endmodule : hsu_host_model

/* dv/hsu_top_tb.sv */
// Self-checking bench for the host serial port.
`timescale 1ns/1ns
module hsu_top_tb;
  import hsu_pkg::*;
  logic        clk, srst, h5, xoe, ld, ab_go, slp, tx_v, rx_r;
  logic        s_in, s_out, rts_n, cts_n, ab_busy, wake, tx_rdy, rx_v, ovr, ferr, paused;
  logic [15:0] cdiv, rate;
  hsu_byte_t   tx_in, rx_out;
  int          bad_count = 0;
  int          check_count = 0;
  int          ferr_n = 0;
  int          ovr_n = 0;
  hsu_top dut_u (.clk(clk), .srst(srst), .hci_serial_in(s_in), .hci_serial_out(s_out),
    .hci_request_to_send_n(rts_n), .hci_clear_to_send_n(cts_n), .h5_mode(h5),
    .xon_xoff_en(xoe), .cfg_divisor(cdiv), .cfg_load(ld), .autobaud_start(ab_go),
    .autobaud_busy(ab_busy), .rate_divisor(rate), .sleep_mode(slp), .wake_event(wake),
    .tx_in(tx_in), .tx_in_valid(tx_v), .tx_in_ready(tx_rdy), .rx_out(rx_out),
    .rx_out_valid(rx_v), .rx_out_ready(rx_r), .rx_overrun(ovr), .rx_frame_error(ferr),
    .tx_paused(paused));
  hsu_host_model host_u (.clk(clk), .dev_out(s_out), .rts_n(rts_n), .host_out(s_in),
    .cts_n(cts_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Both flags are one-cycle pulses, so they are counted mid-cycle rather than polled.
  always @(negedge clk) begin
    if (ferr === 1'b1) ferr_n++;
    if (ovr === 1'b1) ovr_n++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic push(input logic [7:0] b, input logic l);
    tx_in = '{l, b};
    tx_v = 1'b1;
    while (tx_rdy !== 1'b1) tick(1);
    tick(1);
    tx_v = 1'b0;
    tick(1);
  endtask : push
  task automatic pop(input logic [8:0] exp);
    int n = 0;
    while (rx_v !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    chk({7'h0, rx_out}, {7'h0, exp});
    rx_r = 1'b1;
    tick(1);
    rx_r = 1'b0;
    tick(1);
  endtask : pop
  task automatic hrx(input logic [7:0] exp);
    int n = 0;
    while (host_u.got.size() == 0 && n < 3000) begin
      tick(1);
      n++;
    end
    if (host_u.got.size() == 0) chk(16'hdead, {8'h0, exp});
    else chk({8'h0, host_u.got.pop_front()}, {8'h0, exp});
  endtask : hrx
  task automatic t_rate();
    logic [15:0] req[3] = '{16'h000a, 16'h4e20, 16'h0020};
    logic [15:0] exp[3] = '{16'h0019, 16'h28b0, 16'h0020};
    chk(rate, 16'h0364);
    chk({15'h0, rts_n}, 16'h0);
    chk({15'h0, s_out}, 16'h1);
    for (int i = 0; i < 3; i++) begin
      cdiv = req[i];
      ld = 1'b1;
      tick(1);
      ld = 1'b0;
      chk(rate, exp[i]);
    end
    host_u.div = 32;
    $display("end rate");
  endtask : t_rate
  task automatic t_tx();
    int n = 0;
    host_u.set_cts(1'b1);
    push(8'ha5, 1'b0);
    tick(100);
    chk({15'h0, s_out}, 16'h1);
    host_u.set_cts(1'b0);
    while (s_out !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    chk({15'h0, n <= 48}, 16'h1);
    hrx(8'ha5);
    push(8'hc0, 1'b0);
    hrx(8'hc0);
    h5 = 1'b1;
    push(8'hc0, 1'b0);
    push(8'h41, 1'b1);
    hrx(8'hc0);
    hrx(8'hdb);
    hrx(8'hdc);
    hrx(8'h41);
    hrx(8'hc0);
    $display("end tx");
  endtask : t_tx
  task automatic t_rx();
    int f0;
    host_u.send(8'hdb);
    host_u.send(8'hdc);
    host_u.send(8'hc0);
    h5 = 1'b0;
    host_u.send(8'h5a);
    pop(9'h0c0);
    pop(9'h100);
    pop(9'h05a);
    f0 = ferr_n;
    host_u.stop_bit = 1'b0;
    host_u.send(8'h3c);
    host_u.stop_bit = 1'b1;
    tick(40);
    chk(16'(ferr_n - f0), 16'h0001);
    chk({15'h0, rx_v}, 16'h0);
    chk(16'(ovr_n), 16'h0);
    $display("end rx");
  endtask : t_rx
  task automatic t_xoff();
    xoe = 1'b1;
    host_u.send(8'h13);
    tick(5);
    chk({15'h0, paused}, 16'h1);
    push(8'h77, 1'b0);
    tick(400);
    chk(16'(host_u.got.size()), 16'h0);
    host_u.send(8'h11);
    tick(5);
    chk({15'h0, paused}, 16'h0);
    chk({15'h0, rx_v}, 16'h0);
    hrx(8'h77);
    xoe = 1'b0;
    $display("end xoff");
  endtask : t_xoff
  task automatic t_wake();
    logic w = 1'b0;
    slp = 1'b1;
    tick(2);
    host_u.set_cts(1'b1);
    repeat (4) begin
      tick(1);
      w = w | wake;
    end
    chk({15'h0, w}, 16'h1);
    host_u.set_cts(1'b0);
    slp = 1'b0;
    $display("end wake");
  endtask : t_wake
  task automatic t_auto();
    ab_go = 1'b1;
    tick(1);
    ab_go = 1'b0;
    chk({15'h0, ab_busy}, 16'h1);
    host_u.div = 40;
    host_u.send(8'h01);
    tick(5);
    chk(rate, 16'h0028);
    chk({15'h0, ab_busy}, 16'h0);
    $display("end autobaud");
  endtask : t_auto
  task automatic test_done();
    $display("checks=%0d bad=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    srst = 1'b1;
    {h5, xoe, ld, ab_go, slp, tx_v, rx_r} = 7'h0;
    cdiv = 16'h0020;
    tx_in = '0;
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    tick(2);
    t_rate();
    t_tx();
    t_rx();
    t_xoff();
    t_wake();
    t_auto();
    test_done();
  end
  // The whole run is under ten thousand cycles; this limit is well beyond it.
  initial begin
    #600000;
    bad_count++;
    test_done();
  end
endmodule : hsu_top_tb
